// ### common/fmc_pkg.sv
// ----------------------------------------------------------------
// flash mode control constants
// ----------------------------------------------------------------
package fmc_pkg;
    localparam int         ADDR_W          = 18;
    localparam int         DATA_W          = 32;
    localparam int         CTL_W           = 7;
    // register index; one 32-bit word per index, so byte address is 4x
    localparam logic [15:0] FMC_CTRL_IDX   = 16'hff40;
    localparam logic [ADDR_W-1:0] FMC_CTRL_OFF = {FMC_CTRL_IDX, 2'b00};
    // bit positions inside flash_mode_control
    localparam int         BIT_WP          = 7;
    localparam int         BIT_SW_EN       = 6;
    localparam int         BIT_E_SETUP     = 5;
    localparam int         BIT_P_SETUP     = 4;
    localparam int         BIT_E_VERIFY    = 3;
    localparam int         BIT_P_VERIFY    = 2;
    localparam int         BIT_E           = 1;
    localparam int         BIT_P           = 0;
    // reset and idle values
    localparam logic [6:0] CTL_RESET       = 7'h00;
    localparam logic [7:0] RST_WP_HIGH     = 8'h80;
    localparam logic [7:0] RST_WP_LOW      = 8'h00;
    localparam logic [7:0] DISABLED_READ   = 8'h00;
    localparam logic [31:0] RDATA_IDLE     = 32'h0000_0000;
    // operating modes seen on the mode pins
    localparam logic [2:0] MODE_NO_PROG    = 3'h6;
    localparam logic [2:0] MODE_FLASH_MIN  = 3'h5;
endpackage : fmc_pkg

// ### logic/fmc_flash_mode_control.sv
// Operation
// RQ1 - verify modes reachable only after software enable set with pin high
// RQ2 - software enters program: enable, then program setup, then program
// RQ3 - software enters erase: enable, then erase setup, then erase
// RQ4 - register cleared by reset, hardware standby and software standby
// RQ5 - register reads 0x80 after reset with pin high, else 0x00
// RQ6 - in mode 6 no bit of the register can be set
// RQ7 - flash disabled: reads return 0x00, writes ignored
// RQ8 - software raises bits 6 to 0 one per write
// RQ9 - setup and verify bits writable only with pin and enable high
// RQ10 - erase bit writable only with pin, enable, erase setup high
// RQ11 - program bit writable only with pin, enable, program setup high
// RQ12 - bit 7 shows the protect pin level
// RQ13 - bit 6 enables program/erase, resets 0, settable only with pin high
// RQ14 - software sets enable before other control or block select bits
// RQ15 - bit 5 erase setup, resets 0, gated by pin and enable
// RQ16 - bit 4 program setup, resets 0, gated by pin and enable
// RQ17 - bit 3 selects erase-verify mode, resets 0
// RQ18 - bit 2 selects program-verify mode, resets 0
// RQ19 - bit 1 enters erase mode when set, leaves when cleared
// RQ20 - bit 0 enters program mode when set, leaves when cleared
// RQ21 - software never changes enable together with other control bits
// RQ22 - bit 7 read-only, follows synchronised pin
`timescale 1ns/1ps
module fmc_flash_mode_control
    import fmc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [DATA_W-1:0] pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              write_protect_pin,
    input  wire logic [2:0]        mode_pins,
    input  wire logic              hw_standby,
    input  wire logic              sw_standby,
    output logic                   write_protect_pin_level,
    output logic                   software_write_enable,
    output logic                   erase_setup,
    output logic                   program_setup,
    output logic                   erase_verify,
    output logic                   program_verify,
    output logic                   erase_mode,
    output logic                   program_mode,
    output logic                   verify_allowed
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic       wp_meta;
    logic       wp_lvl;
    logic [2:0] md_meta;
    logic [2:0] md;
    logic       hs_meta;
    logic       hs;
    logic       next_wp_meta;
    logic       next_wp_lvl;
    logic [2:0] next_md_meta;
    logic [2:0] next_md;
    logic       next_hs_meta;
    logic       next_hs;

    always_comb begin
        next_wp_meta = write_protect_pin;
        next_wp_lvl  = wp_meta;
        next_md_meta = mode_pins;
        next_md      = md_meta;
        next_hs_meta = hw_standby;
        next_hs      = hs_meta;
    end

    // no reset here: bit 7 must reflect the pin while reset is held
    always_ff @(posedge clk) begin
        if (ce) begin
            wp_meta <= next_wp_meta;
            wp_lvl  <= next_wp_lvl;
            md_meta <= next_md_meta;
            md      <= next_md;
            hs_meta <= next_hs_meta;
            hs      <= next_hs;
        end
    end

    // ----------------------------------------------------------------
    // write gating
    // ----------------------------------------------------------------
    logic flash_on;
    logic mode6;
    logic hit;
    logic wr;

    assign flash_on = (md >= MODE_FLASH_MIN);
    assign mode6    = (md == MODE_NO_PROG);                     // [RQ6]
    assign hit      = (paddr == FMC_CTRL_OFF);
    assign wr       = psel && penable && pwrite && hit && pstrb[0]
                      && flash_on;                              // [RQ7]

    function automatic logic [6:0] fmc_apply(
        input logic [6:0] cur,
        input logic [7:0] d,
        input logic       wp,
        input logic       m6
    );
        logic [6:0] res;
        logic       gate;
        res  = cur;
        gate = wp && cur[BIT_SW_EN];
        // clearing the enable is always honoured, setting needs the pin
        if (!d[BIT_SW_EN])
            res[BIT_SW_EN] = 1'b0;
        else if (wp)
            res[BIT_SW_EN] = 1'b1;                              // [RQ13]
        if (gate) begin
            res[BIT_E_SETUP]  = d[BIT_E_SETUP];                 // [RQ9] [RQ15]
            res[BIT_P_SETUP]  = d[BIT_P_SETUP];                 // [RQ9] [RQ16]
            res[BIT_E_VERIFY] = d[BIT_E_VERIFY];     // [RQ1] [RQ9] [RQ17]
            res[BIT_P_VERIFY] = d[BIT_P_VERIFY];     // [RQ1] [RQ9] [RQ18]
        end
        if (gate && cur[BIT_E_SETUP])
            res[BIT_E] = d[BIT_E];                              // [RQ10] [RQ19]
        if (gate && cur[BIT_P_SETUP])
            res[BIT_P] = d[BIT_P];                              // [RQ11] [RQ20]
        // mode 6 may clear bits but never raise one
        if (m6)
            res = res & cur;                                    // [RQ6]
        return res;
    endfunction : fmc_apply

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    logic [6:0] ctl;
    logic [6:0] next_ctl;

    always_comb begin
        next_ctl = ctl;
        // standby acts on the level, so a long standby keeps bits clear
        if (hs || sw_standby)
            next_ctl = CTL_RESET;                               // [RQ4]
        else if (!wp_lvl)
            next_ctl = CTL_RESET;
        else if (wr)
            next_ctl = fmc_apply(ctl, pwdata[7:0], wp_lvl, mode6);
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            ctl <= CTL_RESET;                                   // [RQ4] [RQ5]
        else if (ce)
            ctl <= next_ctl;
    end

    // ----------------------------------------------------------------
    // apb read path
    // ----------------------------------------------------------------
    logic [7:0]        view;
    logic [DATA_W-1:0] next_prdata;

    // bit 7 is never stored, so writes cannot touch it
    assign view = flash_on ? {wp_lvl, ctl}                     // [RQ12] [RQ22]
                           : DISABLED_READ;                     // [RQ7]

    always_comb begin
        next_prdata = prdata;
        if (psel && !penable)
            next_prdata = (hit && !pwrite) ? {24'h000000, view}
                                           : RDATA_IDLE;
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            prdata <= RDATA_IDLE;
        else if (ce)
            prdata <= next_prdata;
    end

    // stalls the access while the block is frozen
    assign pready  = ce;
    assign pslverr = psel && penable && !hit;

    // ----------------------------------------------------------------
    // mode outputs
    // ----------------------------------------------------------------
    assign write_protect_pin_level = wp_lvl;
    assign software_write_enable   = ctl[BIT_SW_EN];
    assign erase_setup             = ctl[BIT_E_SETUP];
    assign program_setup           = ctl[BIT_P_SETUP];
    assign erase_verify            = ctl[BIT_E_VERIFY];        // [RQ17]
    assign program_verify          = ctl[BIT_P_VERIFY];        // [RQ18]
    assign erase_mode              = ctl[BIT_E];               // [RQ19]
    assign program_mode            = ctl[BIT_P];               // [RQ20]
    assign verify_allowed          = wp_lvl && ctl[BIT_SW_EN]; // [RQ1]

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence rd_setup_off;
        psel && !penable && !pwrite && !flash_on && ce;
    endsequence

    sequence wr_access_off;
        psel && penable && pwrite && !flash_on && wp_lvl
        && !hs && !sw_standby && ce;
    endsequence

    enable_gate_a: assert property ( // [RQ13]
        $rose(software_write_enable) |-> $past(wp_lvl))
        else $error("enable set without protect pin high");

    erase_prep_a: assert property ( // [RQ15]
        $rose(erase_setup) |-> $past(wp_lvl && software_write_enable))
        else $error("erase setup set without enable");

    prog_prep_a: assert property ( // [RQ16]
        $rose(program_setup) |-> $past(wp_lvl && software_write_enable))
        else $error("program setup set without enable");

    verify_gate_a: assert property ( // [RQ1] [RQ9]
        $rose(erase_verify || program_verify)
        |-> $past(wp_lvl && software_write_enable))
        else $error("verify bit set without enable");

    erase_gate_a: assert property ( // [RQ10]
        $rose(erase_mode)
        |-> $past(wp_lvl && software_write_enable && erase_setup))
        else $error("erase set without erase setup");

    prog_gate_a: assert property ( // [RQ11]
        $rose(program_mode)
        |-> $past(wp_lvl && software_write_enable && program_setup))
        else $error("program set without program setup");

    mode6_lock_a: assert property ( // [RQ6]
        mode6 && ce |=> ((ctl & ~$past(ctl)) == 7'h00))
        else $error("bit raised in mode 6");

    standby_clear_a: assert property ( // [RQ4]
        (hs || sw_standby) && ce |=> ctl == CTL_RESET)
        else $error("standby did not clear register");

    reset_value_a: assert property ( // [RQ4] [RQ5]
        $rose(rst_n) |-> ctl == CTL_RESET)
        else $error("register not cleared by reset");

    disabled_read_a: assert property ( // [RQ7]
        rd_setup_off |=> prdata == RDATA_IDLE)
        else $error("disabled flash read not zero");

    disabled_write_a: assert property ( // [RQ7]
        wr_access_off |=> ctl == $past(ctl))
        else $error("write took effect with flash off");

    pin_view_a: assert property ( // [RQ12] [RQ22]
        psel && !penable && !pwrite && hit && flash_on && ce
        |=> prdata[7:0] == {$past(wp_lvl), $past(ctl)})
        else $error("bit 7 does not show protect pin");

    // a mapped write that can land: pin high, no standby, not frozen
    sequence open_write;
        wr && wp_lvl && ce && !hs && !sw_standby;
    endsequence

    setup_shut_a: assert property ( // [RQ9]
        open_write ##0 !software_write_enable
        |=> $stable(ctl[BIT_E_SETUP:BIT_P_VERIFY]))
        else $error("setup or verify bit written without enable");

    erase_shut_a: assert property ( // [RQ10]
        open_write ##0 (software_write_enable && !erase_setup)
        |=> $stable(erase_mode))
        else $error("erase bit written without erase setup");

    prog_shut_a: assert property ( // [RQ11]
        open_write ##0 (software_write_enable && !program_setup)
        |=> $stable(program_mode))
        else $error("program bit written without program setup");

    enable_clear_a: assert property ( // [RQ13]
        open_write ##0 !pwdata[BIT_SW_EN]
        |=> !software_write_enable)
        else $error("enable bit did not clear");

    pin_low_clear_a: assert property ( // [RQ13]
        !wp_lvl && ce |=> ctl == CTL_RESET)
        else $error("control bits kept with protect pin low");

    // the bus only sees one word, anything else must bounce off
    unmapped_write_a: assert property (
        psel && penable && pwrite && !hit && ce && wp_lvl
        && !hs && !sw_standby |=> $stable(ctl))
        else $error("write to unmapped address changed register");

    freeze_hold_a: assert property (
        !ce |=> $stable(ctl) && $stable(prdata))
        else $error("state changed while clock enable low");

endmodule : fmc_flash_mode_control

// ### tb/fmc_cpu_model.sv
`timescale 1ns/1ps
module fmc_cpu_model
    import fmc_pkg::*;
(
    input  wire logic              clk,
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic      [ADDR_W-1:0] paddr,
    output logic      [DATA_W-1:0] pwdata,
    output logic      [3:0]        pstrb,
    input  wire logic [DATA_W-1:0] prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
        pstrb   = 4'h1;
    end
    // ----------------------------------------------------------------
    // one apb transfer, held until pready
    // ----------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q, output logic err);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // parked bus shows inverted leftovers, not a stale request
        paddr  <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : fmc_cpu_model

// ### tb/flash_mode_control_register_bench.sv
`timescale 1ns/1ps
module flash_mode_control_register_bench;
    import fmc_pkg::*;
    logic clk, rst_n, ce, wp, hws, sws, psel, penable, pwrite, pready, err;
    logic [2:0] mode;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic wen, eset, pset, ever, pver, em, pm, wpl, vfy, pslverr;
    logic [6:0] ctl;
    logic [7:0] seq [15] = '{8'h3f, 8'h40, 8'h41, 8'h50, 8'h51, 8'h50,
        8'h40, 8'h42, 8'h60, 8'h62, 8'h60, 8'h40, 8'h48, 8'h44, 8'hc4};
    int miscompares, checks_done;
    fmc_cpu_model fmc_cpu_model_inst (.clk(clk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    fmc_flash_mode_control fmc_flash_mode_control_inst (.clk(clk),
        .rst_n(rst_n), .ce(ce), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .write_protect_pin(wp), .mode_pins(mode), .hw_standby(hws),
        .sw_standby(sws), .write_protect_pin_level(wpl),
        .software_write_enable(wen), .erase_setup(eset),
        .program_setup(pset), .erase_verify(ever), .program_verify(pver),
        .erase_mode(em), .program_mode(pm), .verify_allowed(vfy));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // expectation and checking
    // ----------------------------------------------------------------
    function automatic logic [6:0] exp_next(input logic [6:0] c,
        input logic [7:0] d, input logic w, input logic m6);
        logic [6:0] n;
        logic       g;
        g = w & c[6];
        n = c;
        n[6] = d[6] & w;
        if (g) n[5:2] = d[5:2];
        if (g & c[5]) n[1] = d[1];
        if (g & c[4]) n[0] = d[0];
        if (m6) n = n & c;
        return w ? n : 7'h00;
    endfunction : exp_next
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic step(input logic [7:0] d);
        fmc_cpu_model_inst.xfer(1'b1, FMC_CTRL_OFF, {24'h0, d}, q, err);
        if (mode >= MODE_FLASH_MIN) ctl = exp_next(ctl, d, wp, mode == 3'h6);
    endtask : step
    task automatic look();
        logic [31:0] e, g;
        fmc_cpu_model_inst.xfer(1'b0, FMC_CTRL_OFF, 32'h0, q, err);
        e = (mode >= MODE_FLASH_MIN) ? {24'h0, wp, ctl} : 32'h0;
        chk("ctrl", e, q);
        g = {25'h0, wen, eset, pset, ever, pver, em, pm};
        chk("bits", {25'h0, ctl}, g);
        chk("pin", {31'h0, wp}, {31'h0, wpl});
        chk("verify", {31'h0, wp & ctl[6]}, {31'h0, vfy});
    endtask : look
    task automatic pins(input logic w, input logic [2:0] m);
        wp   <= w;
        mode <= m;
        repeat (3) @(posedge clk);
        if (!w) ctl = 7'h00;
    endtask : pins
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        #400000;
        miscompares++;
        complete_run();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst_n, hws, sws, ctl, miscompares, checks_done} = '0;
        {ce, wp, mode} = 5'h1f;
        void'($urandom(32'h4a6e761d));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        look();
        foreach (seq[i]) begin
            step(seq[i]);
            look();
        end
        repeat (150) begin
            step(8'(ctl ^ (7'h1 << $urandom_range(6, 0))));
            look();
        end
        // mid-run reset, then hardware and software standby
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        ctl = 7'h00;
        look();
        for (int i = 0; i < 2; i++) begin
            step(8'h40);
            step(8'h50);
            {hws, sws} <= (i == 0) ? 2'b10 : 2'b01;
            repeat (4) @(posedge clk);
            {hws, sws} <= 2'b00;
            ctl = 7'h00;
            repeat (3) @(posedge clk);
            look();
        end
        pins(1'b1, 3'h6);
        step(8'h40);
        look();
        pins(1'b1, 3'h3);
        look();
        step(8'h40);
        pins(1'b1, 3'h7);
        look();
        step(8'h40);
        pins(1'b0, 3'h7);
        look();
        step(8'hc0);
        look();
        pins(1'b1, 3'h7);
        fmc_cpu_model_inst.xfer(1'b1, FMC_CTRL_OFF + 12'h4, 32'h40, q, err);
        chk("slverr", 32'h1, {31'h0, err});
        look();
        // lowest enabled mode and the one just below it
        pins(1'b1, 3'h5);
        step(8'h40);
        look();
        pins(1'b1, 3'h4);
        look();
        pins(1'b1, 3'h7);
        // frozen block stalls the bus and keeps its bits
        ce <= 1'b0;
        fork
            step(8'h00);
            begin
                repeat (4) @(posedge clk);
                chk("ready", 32'h0, {31'h0, pready});
                chk("frozen", {25'h0, ctl},
                    {25'h0, wen, eset, pset, ever, pver, em, pm});
                ce <= 1'b1;
            end
        join
        look();
        complete_run();
    end
endmodule : flash_mode_control_register_bench
